// ==== aspwm_defines.svh ====
`ifndef ASPWM_DEFINES_SVH
`define ASPWM_DEFINES_SVH

// Register byte offsets
`define ASPWM_OFS_CTRL 32'h0000_0000
`define ASPWM_OFS_GAIN 32'h0000_0004
`define ASPWM_OFS_OFFSET 32'h0000_0008
`define ASPWM_OFS_LO_LIM 32'h0000_000C
`define ASPWM_OFS_HI_LIM 32'h0000_0010
`define ASPWM_OFS_PERIOD 32'h0000_0014
`define ASPWM_OFS_STATUS 32'h0000_0018
`define ASPWM_OFS_SCALED 32'h0000_001C

// Control and status field positions
`define ASPWM_CTRL_EN_BIT 0
`define ASPWM_CTRL_SRC_BIT 1
`define ASPWM_CTRL_TB_LSB 2
`define ASPWM_STATUS_OUT_BIT 0
`define ASPWM_STATUS_RUN_BIT 1
`define ASPWM_STATUS_HIGH_LSB 16

// Reset values (gain in hundredths)
`define ASPWM_RST_GAIN 16'h0064
`define ASPWM_RST_OFFSET 16'h0000
`define ASPWM_RST_LO_LIM 16'h0000
`define ASPWM_RST_HI_LIM 16'h03E8
`define ASPWM_RST_PERIOD 16'h0004

// Parameter limits, magnitudes
`define ASPWM_GAIN_LIM 16'h03E8
`define ASPWM_OFFSET_LIM 16'h2710
`define ASPWM_RANGE_LIM 16'h4E20
`define ASPWM_GAIN_SCALE 32'h0000_0064

// Timing: clock period and timebase units
`define ASPWM_CLK_PERIOD_NS 64'd100
`define ASPWM_TB_10MS_MS 64'd10
`define ASPWM_TB_100MS_MS 64'd100
`define ASPWM_TB_1S_MS 64'd1000
`define ASPWM_TB_1MIN_MS 64'd60000
`define ASPWM_NS_PER_MS 64'd1000000

// AXI responses
`define ASPWM_RESP_OKAY 2'h0
`define ASPWM_RESP_SLVERR 2'h2

`endif

// ==== aspwm_pkg.sv ====
package aspwm_pkg;

    typedef logic signed [15:0] aspwm_sample_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ASPWM_IDLE = 3'b001,
        ASPWM_CALC = 3'b010,
        ASPWM_RUN = 3'b100
    } aspwm_fsm_t;

    // Software-visible settings
    typedef struct packed {
        logic en;
        logic src_ext;
        logic [1:0] tb_sel;
        logic signed [15:0] gain;
        logic signed [15:0] offset;
        logic signed [15:0] lo_lim;
        logic signed [15:0] hi_lim;
        logic [15:0] period;
    } aspwm_regs_t;

    // Whole state of the top module
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic have_aw;
        logic have_w;
        logic [31:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        aspwm_regs_t regs;
        aspwm_fsm_t fsm;
        logic en_q;
        logic [31:0] tb_cnt;
        logic [15:0] tick_cnt;
        logic [15:0] period_cur;
        logic [15:0] high_ticks;
        logic signed [31:0] x_cur;
        logic div_start;
        logic pwm_out;
    } aspwm_state_t;

    // Whole state of the divider
    typedef struct packed {
        logic busy;
        logic [5:0] cnt;
        logic [32:0] rem;
        logic [47:0] quo;
        logic [31:0] dvs;
        logic done;
    } aspwm_div_state_t;

endpackage

// ==== aspwm_div_if.sv ====
`timescale 1ns/1ps
interface aspwm_div_if;
    logic start;
    logic [47:0] dividend;
    logic [31:0] divisor;
    logic done;
    logic [15:0] quotient;

    modport ctrl (output start, output dividend, output divisor, input done, input quotient);
    modport unit (input start, input dividend, input divisor, output done, output quotient);
endinterface

// ==== aspwm_divider.sv ====
`timescale 1ns/1ps
module aspwm_divider (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Request and result
    aspwm_div_if.unit div
);
    import aspwm_pkg::*;

    aspwm_div_state_t s;
    aspwm_div_state_t next_s;
    logic [32:0] trial;

    assign div.done = s.done;
    assign div.quotient = s.quo[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Restoring division, one quotient bit a cycle; a new start restarts
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        trial = {s.rem[31:0], s.quo[47]};
        if (div.start) begin
            next_s.busy = 1'b1;
            next_s.cnt = 6'h00;
            next_s.rem = 33'h0;
            next_s.quo = div.dividend;
            next_s.dvs = div.divisor;
        end else if (s.busy) begin
            next_s.quo = {s.quo[46:0], 1'b0};
            if (trial >= {1'b0, s.dvs}) begin
                next_s.rem = trial - {1'b0, s.dvs};
                next_s.quo[0] = 1'b1;
            end else begin
                next_s.rem = trial;
            end
            next_s.cnt = s.cnt + 6'h01;
            if (s.cnt == 6'h2F) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ==== aspwm_top.sv ====
// Summary of operation
// - Modulation starts on a 0-to-1 change of the enable bit, never on its level alone.
// - The scaled value is the analog sample times a signed gain of up to 10.00 plus an offset of up to 10000.
// - Signed lower and upper limits, each within 20000, set the span used for normalising.
// - Strictly between the limits, the high share of a period is (value - lower) / (upper - lower).
// - In each period the output is high for that share of the period and low for the rest.
// - The high-then-low pattern repeats period after period while enable stays high.
// - The period is a fixed setting or a live external value, counted in a selectable timebase.
`timescale 1ns/1ps
`include "aspwm_defines.svh"
module aspwm_top #(
    parameter int unsigned TB_10MS_CYCLES =
        32'(`ASPWM_TB_10MS_MS * (`ASPWM_NS_PER_MS / `ASPWM_CLK_PERIOD_NS)),
    parameter int unsigned TB_100MS_CYCLES =
        32'(`ASPWM_TB_100MS_MS * (`ASPWM_NS_PER_MS / `ASPWM_CLK_PERIOD_NS)),
    parameter int unsigned TB_1S_CYCLES =
        32'(`ASPWM_TB_1S_MS * (`ASPWM_NS_PER_MS / `ASPWM_CLK_PERIOD_NS)),
    parameter int unsigned TB_1MIN_CYCLES =
        32'(`ASPWM_TB_1MIN_MS * (`ASPWM_NS_PER_MS / `ASPWM_CLK_PERIOD_NS))
) (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // AXI4-Lite write
    input logic [31:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // AXI4-Lite read
    input logic [31:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Analog sources
    input aspwm_pkg::aspwm_sample_t analog_sample_in,
    input logic [15:0] period_ext_in,
    // Modulated output
    output logic pwm_out
);
    import aspwm_pkg::*;

    aspwm_state_t s;
    aspwm_state_t next_s;
    aspwm_div_if div ();
    logic [31:0] strb_mask;
    logic [3:0] w_idx;
    logic [3:0] r_idx;
    logic [31:0] merged;
    logic signed [31:0] a32;
    logic signed [31:0] x_now;
    logic signed [31:0] lo_x;
    logic signed [31:0] hi_x;
    logic signed [31:0] den;
    logic [15:0] per;
    logic tb_tick;
    logic start_period;

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by reads and writes; 4'hF means unmapped
    function automatic logic [3:0] reg_index(input logic [31:0] addr);
        if (addr[31:5] != 27'h0 || addr[1:0] != 2'h0) begin
            return 4'hF;
        end
        return {1'b0, addr[4:2]};
    endfunction

    // Readback of one register
    function automatic logic [31:0] read_reg(input logic [3:0] idx, input aspwm_state_t st);
        logic [31:0] v;
        v = 32'h0;
        case (idx)
            4'h0: begin
                v[`ASPWM_CTRL_EN_BIT] = st.regs.en;
                v[`ASPWM_CTRL_SRC_BIT] = st.regs.src_ext;
                v[`ASPWM_CTRL_TB_LSB +: 2] = st.regs.tb_sel;
            end
            4'h1: v = 32'(st.regs.gain);
            4'h2: v = 32'(st.regs.offset);
            4'h3: v = 32'(st.regs.lo_lim);
            4'h4: v = 32'(st.regs.hi_lim);
            4'h5: v = {16'h0, st.regs.period};
            4'h6: begin
                v[`ASPWM_STATUS_OUT_BIT] = st.pwm_out;
                v[`ASPWM_STATUS_RUN_BIT] = (st.fsm != ASPWM_IDLE);
                v[`ASPWM_STATUS_HIGH_LSB +: 16] = st.high_ticks;
            end
            4'h7: v = st.x_cur;
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    // Saturate a written field to a symmetric signed limit
    function automatic logic signed [15:0] sat16(input logic [31:0] v, input logic [15:0] lim);
        logic signed [15:0] sv;
        logic signed [15:0] sl;
        sv = signed'(v[15:0]);
        sl = signed'(lim);
        if (sv > sl) begin
            return sl;
        end
        if (sv < -sl) begin
            return -sl;
        end
        return sv;
    endfunction

    // Byte-lane mask from the captured strobes
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign strb_mask[8*g +: 8] = {8{s.w_strb[g]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign pwm_out = s.pwm_out;

    // Divider request: inputs stay stable in the state register while it runs
    assign div.start = s.div_start;
    assign div.dividend = 48'($unsigned(s.x_cur - lo_x)) * {32'h0, s.period_cur};
    assign div.divisor = $unsigned(den);

    aspwm_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .div(div)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: register bus, then the modulation sequencer
    always_comb begin
        next_s = s;
        next_s.div_start = 1'b0;
        w_idx = reg_index(s.aw_addr);
        r_idx = reg_index(s_axi_araddr);
        merged = (read_reg(w_idx, s) & ~strb_mask) | (s.w_data & strb_mask);

        // Write address and data, taken in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.have_aw = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.have_w = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // Commit once both halves are held and the last answer is gone
        if (s.have_aw && s.have_w && !s.bvalid) begin
            next_s.have_aw = 1'b0;
            next_s.have_w = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = (w_idx > 4'h5) ? `ASPWM_RESP_SLVERR : `ASPWM_RESP_OKAY;
            case (w_idx)
                4'h0: begin
                    next_s.regs.en = merged[`ASPWM_CTRL_EN_BIT];
                    next_s.regs.src_ext = merged[`ASPWM_CTRL_SRC_BIT];
                    next_s.regs.tb_sel = merged[`ASPWM_CTRL_TB_LSB +: 2];
                end
                4'h1: next_s.regs.gain = sat16(merged, `ASPWM_GAIN_LIM);
                4'h2: next_s.regs.offset = sat16(merged, `ASPWM_OFFSET_LIM);
                4'h3: next_s.regs.lo_lim = sat16(merged, `ASPWM_RANGE_LIM);
                4'h4: next_s.regs.hi_lim = sat16(merged, `ASPWM_RANGE_LIM);
                4'h5: next_s.regs.period = merged[15:0];
                default: ;
            endcase
        end
        next_s.awready = !next_s.have_aw && !next_s.bvalid;
        next_s.wready = !next_s.have_w && !next_s.bvalid;

        // Reads answer one cycle after the address is taken
        if (s_axi_arvalid && s.arready) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rdata = read_reg(r_idx, s);
            next_s.rresp = (r_idx == 4'hF) ? `ASPWM_RESP_SLVERR : `ASPWM_RESP_OKAY;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end

        // Scaled value, kept in hundredths to avoid dividing by the gain scale
        a32 = 32'(analog_sample_in);
        x_now = a32 * 32'(s.regs.gain) + 32'(s.regs.offset) * 32'(`ASPWM_GAIN_SCALE);
        lo_x = 32'(s.regs.lo_lim) * 32'(`ASPWM_GAIN_SCALE);
        hi_x = 32'(s.regs.hi_lim) * 32'(`ASPWM_GAIN_SCALE);
        den = hi_x - lo_x;
        per = s.regs.src_ext ? period_ext_in : s.regs.period;
        if (per == 16'h0) begin
            per = 16'h0001; // Zero period is run as a period of one timebase unit
        end

        // Timebase divider, restarted with every period
        case (s.regs.tb_sel)
            2'h0: tb_tick = (s.tb_cnt >= TB_10MS_CYCLES - 1);
            2'h1: tb_tick = (s.tb_cnt >= TB_100MS_CYCLES - 1);
            2'h2: tb_tick = (s.tb_cnt >= TB_1S_CYCLES - 1);
            default: tb_tick = (s.tb_cnt >= TB_1MIN_CYCLES - 1);
        endcase

        next_s.en_q = s.regs.en;
        start_period = 1'b0;
        case (s.fsm)
            ASPWM_IDLE: begin
                next_s.pwm_out = 1'b0;
                start_period = s.regs.en && !s.en_q;
            end
            ASPWM_CALC: begin
                if (div.done) begin
                    next_s.high_ticks = div.quotient;
                    next_s.fsm = ASPWM_RUN;
                end
            end
            ASPWM_RUN: begin
                next_s.tb_cnt = tb_tick ? 32'h0 : s.tb_cnt + 32'h1;
                next_s.pwm_out = (s.tick_cnt < s.high_ticks);
                if (tb_tick) begin
                    next_s.tick_cnt = s.tick_cnt + 16'h1;
                    start_period = (s.tick_cnt + 16'h1 >= s.period_cur);
                end
            end
            default: next_s.fsm = ASPWM_IDLE;
        endcase

        // New period: sample, then classify against the limits
        if (start_period) begin
            next_s.x_cur = x_now;
            next_s.period_cur = per;
            next_s.tick_cnt = 16'h0;
            next_s.tb_cnt = 32'h0;
            if (den <= 32'sh0 || x_now <= lo_x) begin
                next_s.high_ticks = 16'h0;
                next_s.fsm = ASPWM_RUN;
            end else if (x_now >= hi_x) begin
                next_s.high_ticks = per;
                next_s.fsm = ASPWM_RUN;
            end else begin
                next_s.div_start = 1'b1;
                next_s.fsm = ASPWM_CALC;
            end
        end

        // Dropping enable stops at once and parks the output low
        if (!s.regs.en) begin
            next_s.fsm = ASPWM_IDLE;
            next_s.pwm_out = 1'b0;
            next_s.div_start = 1'b0;
        end
    end

    // State register with defined reset contents
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
            s.fsm <= ASPWM_IDLE;
            s.regs.gain <= `ASPWM_RST_GAIN;
            s.regs.offset <= `ASPWM_RST_OFFSET;
            s.regs.lo_lim <= `ASPWM_RST_LO_LIM;
            s.regs.hi_lim <= `ASPWM_RST_HI_LIM;
            s.regs.period <= `ASPWM_RST_PERIOD;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ==== aspwm_checker_props.sv ====
`timescale 1ns/1ps
`include "aspwm_defines.svh"
module aspwm_checker (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Register bus
    input logic [31:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [31:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // Modulated output
    input logic pwm_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    // Both write channels taken at one edge
    logic wr_take;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    sequence s_wr_taken;
        wr_take;
    endsequence
    // Commit cycle, then the response
    sequence s_wr_answer;
        (!s_axi_awready && !s_axi_bvalid) ##1 s_axi_bvalid;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property ($rose(aresetn) |-> !pwm_out && !s_axi_bvalid
        && !s_axi_rvalid && s_axi_awready && s_axi_arready) else $error("outputs busy after reset");
    a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write response late or early");
    a_ro_write: assert property (s_wr_taken and s_axi_awaddr == `ASPWM_OFS_STATUS |=> ##1
        s_axi_bresp == `ASPWM_RESP_SLVERR) else $error("read-only write not refused");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_bresp_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read answer not one cycle after take");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data not held");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h1C
        |=> s_axi_rresp == `ASPWM_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 32'h1C
        && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == `ASPWM_RESP_OKAY)
        else $error("mapped read refused");
endmodule
bind aspwm_top aspwm_checker u_aspwm_checker (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pwm_out(pwm_out));

// ==== aspwm_partner.sv ====
`timescale 1ns/1ps
module aspwm_partner (
    // Clock
    input logic aclk,
    // Values asked for by the bench
    input aspwm_pkg::aspwm_sample_t sample_req,
    input logic [15:0] period_req,
    // Toward the block
    output aspwm_pkg::aspwm_sample_t analog_sample_in,
    output logic [15:0] period_ext_in,
    // Output consumer
    input logic pwm_out,
    output logic [15:0] pulse_len,
    output logic pulse_done
);
    import aspwm_pkg::*;
    aspwm_sample_t smp = '0;
    logic [15:0] per = '0;
    logic [15:0] run = '0;
    logic [15:0] len = '0;
    logic done = 1'b0;
    assign analog_sample_in = smp;
    assign period_ext_in = per;
    assign pulse_len = len;
    assign pulse_done = done;
    ////////////////////////////////////////////////////////////////////////////////
    // Source values move only on the clock, like a real sampled source
    always @(posedge aclk) begin
        smp <= sample_req;
        per <= period_req;
        done <= 1'b0;
        if (pwm_out) begin
            run <= run + 16'h0001;
        end else if (run != 16'h0000) begin
            len <= run; // Width of the finished high phase
            done <= 1'b1;
            run <= 16'h0000;
        end
    end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
`include "aspwm_defines.svh"
module tb;
    import aspwm_pkg::*;
    localparam int unsigned UNIT [4] = '{4, 8, 16, 32};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_wvalid = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    aspwm_sample_t sample_req = '0;
    aspwm_sample_t analog_sample_in;
    logic [15:0] period_req = '0;
    logic [15:0] period_ext_in, pulse_len;
    logic pulse_done;
    logic [33:0] re;
    logic [31:0] n;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    bit ignore = 1'b0;
    logic [15:0] pq[$];
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    aspwm_top #(.TB_10MS_CYCLES(4), .TB_100MS_CYCLES(8), .TB_1S_CYCLES(16),
        .TB_1MIN_CYCLES(32)) u_aspwm_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .analog_sample_in(analog_sample_in), .period_ext_in(period_ext_in), .pwm_out(pwm_out));
    aspwm_partner u_aspwm_partner (.aclk(aclk), .sample_req(sample_req), .period_req(period_req),
        .analog_sample_in(analog_sample_in), .period_ext_in(period_ext_in), .pwm_out(pwm_out),
        .pulse_len(pulse_len), .pulse_done(pulse_done));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        forever #50 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Write master; bready comes late at random to exercise the hold
    task automatic axi_write(input logic [31:0] addr, input logic [31:0] data,
        input logic [1:0] rs);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        bq.push_back(rs);
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat ($urandom_range(2, 0)) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    // Read master; expectation noted before the request goes out
    task automatic axi_read(input logic [31:0] addr, input logic [31:0] data,
        input logic [1:0] rs);
        rq.push_back({rs, data});
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat ($urandom_range(2, 0)) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // One enabled run: three pulses of known width, then the scaled value, then stop
    task automatic run_case(input int t, input int src, input int smp, input int gain,
        input int ofs, input int per, input int width, input int scaled);
        sample_req <= 16'(smp);
        period_req <= 16'(per);
        axi_write(`ASPWM_OFS_GAIN, 32'(gain), `ASPWM_RESP_OKAY);
        axi_write(`ASPWM_OFS_OFFSET, 32'(ofs), `ASPWM_RESP_OKAY);
        axi_write(`ASPWM_OFS_CTRL, 32'((t << 2) | (src << 1) | 1), `ASPWM_RESP_OKAY);
        repeat (3) pq.push_back(16'(width));
        for (int i = 0; i < 3000 && pq.size() > 0; i++) @(posedge aclk);
        check(32'(pq.size()), 32'h0);
        axi_read(`ASPWM_OFS_SCALED, 32'(scaled), `ASPWM_RESP_OKAY);
        axi_write(`ASPWM_OFS_CTRL, 32'h0, `ASPWM_RESP_OKAY);
        $display("test run timebase %0d source %0d done", t, src);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Hang limit: reaching cycle 20000 counts as a failure and ends the test
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    // Results against their notes
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            re = rq.pop_front();
            check(s_axi_rdata, re[31:0]);
            check({30'h0, s_axi_rresp}, {30'h0, re[33:32]});
        end
        if (s_axi_bvalid && s_axi_bready)
            check({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
        if (pulse_done && !ignore) begin
            re = {18'h0, pq.size() > 0 ? pq.pop_front() : 16'h0};
            check({16'h0, pulse_len}, re[31:0]);
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'hF92FDB57));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`ASPWM_OFS_CTRL, 32'h0, `ASPWM_RESP_OKAY);
        axi_read(`ASPWM_OFS_GAIN, 32'h64, `ASPWM_RESP_OKAY);
        axi_read(`ASPWM_OFS_HI_LIM, 32'h3E8, `ASPWM_RESP_OKAY);
        axi_read(`ASPWM_OFS_PERIOD, 32'h4, `ASPWM_RESP_OKAY);
        axi_read(32'h20, 32'h0, `ASPWM_RESP_SLVERR);
        axi_write(`ASPWM_OFS_STATUS, 32'h1, `ASPWM_RESP_SLVERR);
        axi_write(`ASPWM_OFS_GAIN, 32'h7D0, `ASPWM_RESP_OKAY);
        axi_read(`ASPWM_OFS_GAIN, 32'h3E8, `ASPWM_RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        axi_write(`ASPWM_OFS_GAIN, 32'h32, `ASPWM_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_read(`ASPWM_OFS_GAIN, 32'h332, `ASPWM_RESP_OKAY);
        axi_write(`ASPWM_OFS_HI_LIM, 32'h7530, `ASPWM_RESP_OKAY);
        axi_read(`ASPWM_OFS_HI_LIM, 32'h4E20, `ASPWM_RESP_OKAY);
        axi_write(`ASPWM_OFS_HI_LIM, 32'h3E8, `ASPWM_RESP_OKAY);
        $display("test registers done");
        // Every timebase code with a random sample inside the limits
        for (int t = 0; t < 4; t++) begin
            n = $urandom_range(999, 250);
            run_case(t, 0, n, 100, 0, 0, (n * 4 / 1000) * UNIT[t], n * 100);
        end
        // Live period of 10 units, gain 2.00 and offset 100
        run_case(1, 1, 100, 200, 100, 10, 24, 30000);
        // Below the lower limit, then above the upper one
        for (int k = 0; k < 2; k++) begin
            sample_req <= (k == 1) ? 16'sh07D0 : -16'sh0005;
            axi_write(`ASPWM_OFS_OFFSET, 32'h0, `ASPWM_RESP_OKAY);
            axi_write(`ASPWM_OFS_CTRL, 32'h1, `ASPWM_RESP_OKAY);
            repeat (20) @(posedge aclk);
            n = 0;
            repeat (200) begin
                @(posedge aclk);
                n = n + 32'(pwm_out);
            end
            check(n, (k == 1) ? 32'd200 : 32'd0);
            ignore = 1'b1;
            axi_write(`ASPWM_OFS_CTRL, 32'h0, `ASPWM_RESP_OKAY);
            repeat (4) @(posedge aclk);
            ignore = 1'b0;
            $display("test limit case %0d done", k);
        end
        close_out();
    end
endmodule
